// ==== verilog/adcpk_ctrl.sv ====
// converter control, result registers and pack detection
//
// Behaviour
// - pack source current on above minimum system
// - source current level from wait register field
// - discharge cell when pack input too high
// - three-bit channel field routes converter input
// - sample count code selects one to 256
// - result bits binary weighted across two registers
// - single sample gives equal statistics
// - out-of-limit sample ends multi-sample cycle, interrupt
`include "adcpk_map.svh"
`default_nettype none
module adcpk_ctrl
  import adcpk_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // register port behind the serial host link
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // lower limit held elsewhere
  input  wire logic [10:0] lower_limit,
  // converter core
  output logic      [2:0]  channel_select,
  output logic             ref_external,
  output logic             conv_start,
  input  wire logic        conv_done,
  input  wire logic [9:0]  conv_data,
  // host event
  output logic             limit_irq,
  // pack detection
  input  wire logic        min_system_sense,
  input  wire logic        pack_id_over,
  output logic             pack_id_current_en,
  output logic      [1:0]  pack_id_current_sel,
  output logic             cell_discharge_en
);

  // ----------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------
  wire logic hit_setup  = reg_addr == `ADCPK_OFS_SETUP;
  wire logic hit_res_hi = reg_addr == `ADCPK_OFS_RES_HI;
  wire logic hit_res_lo = reg_addr == `ADCPK_OFS_RES_LO;
  wire logic hit_ulim_h = reg_addr == `ADCPK_OFS_ULIM_HI;
  wire logic hit_ulim_l = reg_addr == `ADCPK_OFS_ULIM_LO;
  wire logic hit_wait   = reg_addr == `ADCPK_OFS_WAIT;

  logic [7:0]   setup_r;
  logic [1:0]   view_r;
  logic [10:0]  ulim_r;
  logic [7:0]   wait_r;
  logic [10:0]  result_r;
  logic [7:0]   rdata_r;
  logic         irq_r;
  logic         disch_r;
  logic         src_en_r;
  logic [8:0]   count_r;
  logic [8:0]   count_nxt;
  adcpk_state_t state_r;
  adcpk_state_t state_nxt;

  wire logic busy    = state_r != ADCPK_IDLE;
  wire logic en_now  = setup_r[`ADCPK_SETUP_EN_BIT];
  wire logic en_wr   = reg_wr && hit_setup &&
                       reg_wdata[`ADCPK_SETUP_EN_BIT];
  // a fresh cycle needs the enable taken from low to high
  wire logic start   = en_wr && !en_now && !busy;
  wire logic view_wr = reg_wr && hit_res_hi && !busy;

  // ----------------------------------------------------------------------
  // sample count decode
  // ----------------------------------------------------------------------
  wire logic [2:0] cnt_code = setup_r[`ADCPK_SETUP_CNT_HI:
                                      `ADCPK_SETUP_CNT_LO];
  logic [8:0] target;
  logic [3:0] avg_shift;
  always_comb begin
    case (cnt_code)
      3'h0:    begin target = 9'h001; avg_shift = 4'h0; end
      3'h1:    begin target = 9'h004; avg_shift = 4'h2; end
      3'h2:    begin target = 9'h008; avg_shift = 4'h3; end
      3'h3:    begin target = 9'h010; avg_shift = 4'h4; end
      3'h4:    begin target = 9'h020; avg_shift = 4'h5; end
      3'h5:    begin target = 9'h040; avg_shift = 4'h6; end
      3'h6:    begin target = 9'h080; avg_shift = 4'h7; end
      default: begin target = 9'h100; avg_shift = 4'h8; end
    endcase
  end

  // ----------------------------------------------------------------------
  // statistics
  // ----------------------------------------------------------------------
  adcpk_sample_t smp;
  adcpk_stats_t  stats;
  assign smp.vld  = (state_r == ADCPK_WAIT) && conv_done;
  assign smp.data = conv_data;

  adcpk_stats u_stats (
    .clk   (clk),
    .rst_b (rst_b),
    .clear (start),
    .smp   (smp),
    .stats (stats)
  );

  wire logic multi    = target != 9'h001;
  wire logic out_lim  = ({1'b0, conv_data} > ulim_r) ||
                        ({1'b0, conv_data} < lower_limit);
  wire logic lim_stop = smp.vld && multi && out_lim;
  wire logic last_smp = smp.vld && (count_r + 9'h001 == target);

  wire logic [17:0] avg_full = stats.sum >> avg_shift;
  logic [10:0] view_val;
  always_comb begin
    case (view_r)
      `ADCPK_VIEW_LAST: view_val = {1'b0, stats.last};
      `ADCPK_VIEW_AVG:  view_val = avg_full[10:0];
      `ADCPK_VIEW_MAX:  view_val = {1'b0, stats.max};
      default:          view_val = {1'b0, stats.min};
    endcase
  end

  // ----------------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      ADCPK_IDLE: begin
        count_nxt = 9'h000;
        if (start) begin
          state_nxt = ADCPK_REQ;
        end
      end
      ADCPK_REQ: begin
        state_nxt = ADCPK_WAIT;
      end
      ADCPK_WAIT: begin
        if (smp.vld) begin
          count_nxt = count_r + 9'h001;
          if (last_smp || lim_stop) begin
            state_nxt = ADCPK_IDLE;
          end else begin
            state_nxt = ADCPK_REQ;
          end
        end
      end
      default: begin
        state_nxt = ADCPK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ADCPK_IDLE;
      count_r <= 9'h000;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      setup_r <= `ADCPK_RST_SETUP;
      view_r  <= `ADCPK_RST_VIEW;
      ulim_r  <= `ADCPK_RST_ULIM;
      wait_r  <= `ADCPK_RST_WAIT;
    end else begin
      if (reg_wr && hit_setup) begin
        setup_r <= reg_wdata;
      end
      if (view_wr) begin
        view_r <= reg_wdata[`ADCPK_RES_VIEW_HI:`ADCPK_RES_VIEW_LO];
      end
      if (reg_wr && hit_ulim_h) begin
        ulim_r[10:8] <= reg_wdata[2:0];
      end
      if (reg_wr && hit_ulim_l) begin
        ulim_r[7:0] <= reg_wdata;
      end
      if (reg_wr && hit_wait) begin
        wait_r <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // result, read data and outputs
  // ----------------------------------------------------------------------
  wire logic [7:0] res_hi = {busy, 2'b00, view_r, result_r[10:8]};
  wire logic [7:0] rd_mux =
      hit_setup  ? setup_r :
      hit_res_hi ? res_hi :
      hit_res_lo ? result_r[7:0] :
      hit_ulim_h ? {5'h00, ulim_r[10:8]} :
      hit_ulim_l ? ulim_r[7:0] :
      hit_wait   ? wait_r : 8'h00;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_r <= 11'h000;
      rdata_r  <= 8'h00;
      irq_r    <= 1'b0;
      disch_r  <= 1'b0;
      src_en_r <= 1'b0;
    end else begin
      if (!busy) begin
        result_r <= view_val;
      end
      if (reg_rd) begin
        rdata_r <= rd_mux;
      end
      irq_r    <= lim_stop;
      disch_r  <= pack_id_over;
      src_en_r <= min_system_sense;
    end
  end

  assign reg_rdata           = rdata_r;
  assign limit_irq           = irq_r;
  assign conv_start          = state_r == ADCPK_REQ;
  assign channel_select      = setup_r[`ADCPK_SETUP_CH_HI:
                                       `ADCPK_SETUP_CH_LO];
  assign ref_external        = setup_r[`ADCPK_SETUP_REF_BIT];
  assign pack_id_current_en  = src_en_r;
  assign pack_id_current_sel = wait_r[`ADCPK_WAIT_ID_HI:
                                      `ADCPK_WAIT_ID_LO];
  assign cell_discharge_en   = disch_r;

endmodule : adcpk_ctrl
`default_nettype wire

// ==== verilog/adcpk_map.svh ====
// register offsets, field positions and reset values of the converter block
`ifndef ADCPK_MAP_SVH
`define ADCPK_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ADCPK_OFS_SETUP      8'h1e
`define ADCPK_OFS_RES_HI     8'h1f
`define ADCPK_OFS_RES_LO     8'h20
`define ADCPK_OFS_ULIM_HI    8'h21
`define ADCPK_OFS_ULIM_LO    8'h22
`define ADCPK_OFS_WAIT       8'h26

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ADCPK_SETUP_EN_BIT   7
`define ADCPK_SETUP_REF_BIT  6
`define ADCPK_SETUP_CH_HI    5
`define ADCPK_SETUP_CH_LO    3
`define ADCPK_SETUP_CNT_HI   2
`define ADCPK_SETUP_CNT_LO   0
`define ADCPK_RES_BUSY_BIT   7
`define ADCPK_RES_VIEW_HI    4
`define ADCPK_RES_VIEW_LO    3
`define ADCPK_WAIT_ID_HI     5
`define ADCPK_WAIT_ID_LO     4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ADCPK_RST_SETUP      8'h00
`define ADCPK_RST_VIEW       2'h0
`define ADCPK_RST_ULIM       11'h7ff
`define ADCPK_RST_WAIT       8'h00

// ----------------------------------------------------------------------
// view codes
// ----------------------------------------------------------------------
`define ADCPK_VIEW_LAST      2'h0
`define ADCPK_VIEW_AVG       2'h1
`define ADCPK_VIEW_MAX       2'h2
`define ADCPK_VIEW_MIN       2'h3

`endif

// ==== verilog/adcpk_pkg.sv ====
// types shared by the converter control block
`default_nettype none
package adcpk_pkg;

  // ----------------------------------------------------------------------
  // control states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ADCPK_IDLE = 3'b001,
    ADCPK_REQ  = 3'b010,
    ADCPK_WAIT = 3'b100
  } adcpk_state_t;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       vld;
    logic [9:0] data;
  } adcpk_sample_t;

  typedef struct packed {
    logic [9:0]  last;
    logic [9:0]  min;
    logic [9:0]  max;
    logic [17:0] sum;
  } adcpk_stats_t;

endpackage : adcpk_pkg
`default_nettype wire

// ==== verilog/adcpk_stats.sv ====
// running last, minimum, maximum and sum of one conversion cycle
`default_nettype none
module adcpk_stats
  import adcpk_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // control
  input  wire logic          clear,
  input  wire adcpk_sample_t smp,
  // result
  output adcpk_stats_t       stats
);

  logic         first_r;
  adcpk_stats_t st_r;
  adcpk_stats_t st_nxt;

  // ----------------------------------------------------------------------
  // accumulate
  // ----------------------------------------------------------------------
  // first sample loads every figure, so one sample gives equal values
  assign st_nxt.last = smp.data;
  assign st_nxt.min  = (first_r || smp.data < st_r.min) ?
                       smp.data : st_r.min;
  assign st_nxt.max  = (first_r || smp.data > st_r.max) ?
                       smp.data : st_r.max;
  assign st_nxt.sum  = first_r ? {8'h00, smp.data} :
                       st_r.sum + {8'h00, smp.data};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_r <= 1'b1;
      st_r    <= '0;
    end else if (clear) begin
      first_r <= 1'b1;
    end else if (smp.vld) begin
      first_r <= 1'b0;
      st_r    <= st_nxt;
    end
  end

  assign stats = st_r;

endmodule : adcpk_stats
`default_nettype wire

// ==== verification/adcpk_props.sv ====
// assertions on the converter control block ports
`default_nettype none
module adcpk_props
  import adcpk_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [10:0] lower_limit,
  // converter core
  input wire logic [2:0]  channel_select,
  input wire logic        ref_external,
  input wire logic        conv_start,
  input wire logic        conv_done,
  input wire logic [9:0]  conv_data,
  input wire logic        limit_irq,
  // pack detection
  input wire logic        min_system_sense,
  input wire logic        pack_id_over,
  input wire logic        pack_id_current_en,
  input wire logic [1:0]  pack_id_current_sel,
  input wire logic        cell_discharge_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_cur_en; min_system_sense |=> pack_id_current_en; endproperty
  a_cur_en: assert property (p_cur_en) else $error("source late");
  property p_dis; !pack_id_over ##1 pack_id_over |=> cell_discharge_en;
  endproperty
  a_dis: assert property (p_dis) else $error("no discharge");
  property p_id_sel; reg_wr && reg_addr == 8'h26
    |=> pack_id_current_sel == $past(reg_wdata[5:4]); endproperty
  a_id_sel: assert property (p_id_sel) else $error("id level");
  property p_chan; reg_wr && reg_addr == 8'h1e
    |=> channel_select == $past(reg_wdata[5:3]); endproperty
  a_chan: assert property (p_chan) else $error("channel");
  property p_setup_rd; reg_rd && !reg_wr && reg_addr == 8'h1e
    |=> reg_rdata[6:3] == {ref_external, channel_select}; endproperty
  a_setup_rd: assert property (p_setup_rd) else $error("setup rd");
  property p_start; conv_start |=> !conv_start; endproperty
  a_start: assert property (p_start) else $error("start width");
  property p_irq_cause; limit_irq |-> $past(conv_done) && !conv_start;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq");
  property p_irq_pulse; limit_irq |=> !limit_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq w");
  c_irq: cover property (limit_irq);
  c_smp: cover property (conv_start ##1 !conv_start [*3] ##1 conv_done);
  c_dis: cover property ($rose(cell_discharge_en));
endmodule : adcpk_props
`default_nettype wire

// ==== verification/adcpk_core_model.sv ====
// converter core stand-in answering sample requests
`default_nettype none
module adcpk_core_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // request and answer
  input  wire logic       conv_start,
  output logic            conv_done,
  output logic      [9:0] conv_data,
  // scenario control
  input  wire logic [3:0] lat,
  input  wire logic [9:0] base,
  output logic      [9:0] idx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_r;
  logic       busy_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {busy_r, wait_r, conv_done, idx, conv_data} <= '0;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        busy_r <= 1'b1;
        wait_r <= lat;
      end else if (busy_r && wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end else if (busy_r) begin
        busy_r    <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= base + idx * 10'h025;
        idx       <= idx + 10'h001;
      end
    end
  end
endmodule : adcpk_core_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the converter control block
`default_nettype none
module tb_top;
  import adcpk_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, reg_wr, reg_rd, conv_start, conv_done, limit_irq;
  logic min_system_sense, pack_id_over, pack_id_current_en, irq_seen;
  logic ref_external, cell_discharge_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [10:0] lower_limit;
  logic [9:0] conv_data, base, idx;
  logic [3:0] lat;
  logic [2:0] channel_select;
  logic [1:0] pack_id_current_sel;
  int bad_count, comparisons, cyc;
  adcpk_ctrl dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .lower_limit, .channel_select, .ref_external, .conv_start,
    .conv_done, .conv_data, .limit_irq, .min_system_sense, .pack_id_over,
    .pack_id_current_en, .pack_id_current_sel, .cell_discharge_en);
  adcpk_core_model core (.clk, .rst_b, .conv_start, .conv_done,
    .conv_data, .lat, .base, .idx);
  // ----------------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------------
  task automatic chk(input logic [10:0] g, input logic [10:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rr(input logic [7:0] a);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1;
  endtask : rr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rr(a);
    chk(11'(reg_rdata), 11'(e));
  endtask : rd
  task automatic idle_wait();
    int i;
    i = 0;
    rr(8'h1f);
    while (reg_rdata[7] !== 1'b0 && i++ < 3000) rr(8'h1f);
    chk(11'(reg_rdata[7]), 11'h000);
  endtask : idle_wait
  task automatic conv_check(input logic [2:0] c);
    logic [9:0] v, e [4];
    logic [17:0] s;
    int sh;
    sh = (c == 3'h0) ? 0 : int'(c) + 1;
    {e[3], e[2], s} = {10'h3ff, 10'h000, 18'h00000};
    for (int k = 0; k < (1 << sh); k++) begin
      v = base + (idx + 10'(k)) * 10'h025;
      s = s + 18'(v);
      if (v > e[2]) e[2] = v;
      if (v < e[3]) e[3] = v;
    end
    {e[0], e[1]} = {v, 10'(s >> sh)};
    wr(8'h1e, {5'h00, c});
    wr(8'h1e, {5'h10, c});
    idle_wait();
    for (int w = 0; w < 4; w++) begin
      wr(8'h1f, {3'h0, 2'(w), 3'h0});
      rd(8'h1f, {3'h0, 2'(w), 1'b0, e[w][9:8]});
      rd(8'h20, e[w][7:0]);
    end
  endtask : conv_check
  task automatic lim(input logic [10:0] up, lo, input logic [9:0] n);
    logic [9:0] i0;
    wr(8'h21, {5'h00, up[10:8]});
    wr(8'h22, up[7:0]);
    i0 = idx;
    lower_limit <= lo;
    base <= 10'h100 - i0 * 10'h025;
    irq_seen = 1'b0;
    wr(8'h1e, 8'h01);
    wr(8'h1e, 8'h81);
    idle_wait();
    chk(11'(idx - i0), 11'(n));
    chk(11'(irq_seen), 11'h001);
  endtask : lim
  task automatic tally_and_finish();
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (limit_irq === 1'b1) irq_seen = 1'b1;
    if (cyc == 60000) begin
      bad_count++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
    end
  end
  initial begin
    {rst_b, reg_wr, reg_rd, min_system_sense, pack_id_over} = '0;
    {reg_addr, reg_wdata, lower_limit, lat, base} = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    wr(8'h20, 8'hff);
    rd(8'h1e, 8'h00);
    rd(8'h1f, 8'h00);
    rd(8'h20, 8'h00);
    rd(8'h21, 8'h07);
    rd(8'h22, 8'hff);
    rd(8'h40, 8'h00);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      {min_system_sense, pack_id_over} <= {2{p[0]}};
      wr(8'h26, {2'h0, 1'b1, p[0], 4'h0});
      rd(8'h26, {2'h0, 1'b1, p[0], 4'h0});
      chk(11'(pack_id_current_en), 11'(p));
      chk(11'(cell_discharge_en), 11'(p));
      chk(11'(pack_id_current_sel), 11'(p + 2));
    end
    for (int ch = 0; ch < 8; ch++) begin
      wr(8'h1e, {2'h1, 3'(ch), 3'h0});
      @(negedge clk);
      chk(11'(channel_select), 11'(ch));
      chk(11'(ref_external), 11'h001);
    end
    lim(11'h13f, 11'h000, 10'h003);
    lim(11'h7ff, 11'h101, 10'h001);
    wr(8'h21, 8'h00);
    wr(8'h22, 8'h00);
    irq_seen = 1'b0;
    conv_check(3'h0);
    chk(11'(irq_seen), 11'h000);
    wr(8'h21, 8'h07);
    wr(8'h22, 8'hff);
    {lower_limit, lat} <= {11'h000, 4'h2};
    for (int c = 1; c < 8; c++) conv_check(3'(c));
    wr(8'h1f, 8'h00);
    lat <= 4'hf;
    wr(8'h1e, 8'h02);
    wr(8'h1e, 8'h82);
    rr(8'h1f);
    chk(11'(reg_rdata[7]), 11'h001);
    wr(8'h1f, 8'h18);
    idle_wait();
    chk(11'(reg_rdata[4:3]), 11'h000);
    wr(8'h1e, 8'h82);
    rr(8'h1f);
    chk(11'(reg_rdata[7]), 11'h000);
    tally_and_finish();
  end
endmodule : tb_top
bind adcpk_ctrl adcpk_props u_props (.clk, .rst_b, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .lower_limit, .channel_select, .ref_external,
  .conv_start, .conv_done, .conv_data, .limit_irq, .min_system_sense,
  .pack_id_over, .pack_id_current_en, .pack_id_current_sel,
  .cell_discharge_en);
`default_nettype wire
